// ==== hw/global_control.sv ====
// Purpose: Global pin control: driver enable, rate mode, GPIO, reset, alert, host port select.
// Assumes: Pins are synchronised here; pulled-up pins read high when open.
// Notes: Configuration bits come from the register file as ports.
// Behaviour
// - Driver enable high enables, low tristates drivers
// - Driver enable touches only driver outputs
// - Enable open: global mode; low: per-channel bit
// - Hardware select low E1, open T1/J1
// - Enable low ignores hardware select entirely
// - Each GPIO direction from its own bit
// - Level bits report input, drive output
// - Reset pulse resets device within 2 us
// - Alert asserted for any unmasked pending source
// - Alert drive type, polarity from config field
// - Host port responds only while select low
// - Kind strap: ground serial, supply parallel
// - Mode decides which host pins are used
// - Bus style: ground strobe+rw, open separate strobes
// - Multiplex strap: ground plain, open multiplexed
`default_nettype none
module global_control (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // Device pins
  input  wire logic                    reset_n_pin,
  input  wire logic                    driver_enable_pin,
  input  wire logic                    hw_rate_mode_enable,
  input  wire logic                    hw_rate_mode_select,
  input  wire logic [1:0]              gpio_in,
  output logic      [1:0]              gpio_out,
  output logic      [1:0]              gpio_oe,
  output logic                         host_alert_out,
  output logic                         host_alert_oe,
  input  wire logic                    chip_select_n,
  input  wire logic                    port_kind_strap,
  input  wire logic                    parallel_bus_style_select,
  input  wire logic                    bus_multiplex_select,
  // Register file side
  input  wire logic [21:0]             channel_rate_mode_bit,
  input  wire logic [3:0]              gpio_reg,
  input  wire logic [3:0]              global_config_reg,
  input  wire logic [21:0]             irq_pending,
  input  wire logic [21:0]             irq_mask,
  output logic      [1:0]              gpio_level_read,
  // Line driver and mode outputs
  output logic                         line_driver_enable,
  output logic      [21:0]             channel_rate_mode,
  // Device reset
  output logic                         device_reset,
  // Host port selection
  output logic      [1:0]              host_port_kind,
  output logic                         host_port_multiplexed,
  output logic                         host_port_active
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Pulled-up pins default high at reset.
  logic [1:0] gpio_sync;
  logic [7:0] ctl_sync;

  pin_sync #(.WIDTH(2), .INIT(2'h0)) u_gpio_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (gpio_in),
    .level   (gpio_sync)
  );

  pin_sync #(.WIDTH(8), .INIT(8'hff)) u_ctl_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     ({reset_n_pin, driver_enable_pin, hw_rate_mode_enable,
                hw_rate_mode_select, chip_select_n, port_kind_strap,
                parallel_bus_style_select, bus_multiplex_select}),
    .level   (ctl_sync)
  );

  logic rst_n_s;
  logic oe_s;
  logic hwe_s;
  logic hws_s;
  logic cs_n_s;
  logic kind_s;
  logic style_s;
  logic mux_s;
  // Open pins are pulled up externally, so open and high are one level.
  assign {rst_n_s, oe_s, hwe_s, hws_s, cs_n_s, kind_s, style_s, mux_s} = ctl_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware reset sequencer.
  localparam logic [5:0] RST_LEN = 6'(glob_ctl_pkg::RESET_SEQ_CYCLES -
                                      glob_ctl_pkg::PIN_SYNC_CYCLES);
  logic [5:0] rst_cnt;
  logic [5:0] next_rst_cnt;
  logic       next_device_reset;

  always_comb
  begin
    next_rst_cnt = rst_cnt;
    next_device_reset = device_reset;
    if (!rst_n_s)
    begin
      next_rst_cnt = 6'h00;
      next_device_reset = 1'b1;
    end
    else if (rst_cnt != RST_LEN)
    begin
      // The filter delay is taken off the count, so the sequence fits in 2 us.
      next_rst_cnt = rst_cnt + 6'h01;
      next_device_reset = (rst_cnt + 6'h01) != RST_LEN;
    end
    else
    begin
      next_device_reset = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rst_cnt <= 6'h00;
      device_reset <= 1'b1;
    end
    else
    begin
      rst_cnt <= next_rst_cnt;
      device_reset <= next_device_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modes, GPIO, alert and host port selection.
  function automatic logic alert_level(input logic pend, input logic [1:0] style);
    // Style bit 1 selects active high; bit 0 selects push-pull.
    alert_level = style[1] ? pend : ~pend;
  endfunction

  logic        in_reset;
  logic        any_irq;
  logic [1:0]  alert_style;
  logic        next_line_driver_enable;
  logic [21:0] next_channel_rate_mode;
  logic [1:0]  next_gpio_out;
  logic [1:0]  next_gpio_oe;
  logic [1:0]  next_gpio_level_read;
  logic        next_host_alert_out;
  logic        next_host_alert_oe;
  logic [1:0]  next_host_port_kind;
  logic        next_host_port_multiplexed;
  logic        next_host_port_active;

  assign in_reset = device_reset;
  assign alert_style = global_config_reg[glob_ctl_pkg::ALERT_STYLE_LSB +: 2];

  always_comb
  begin
    // Only the driver state follows the pin; nothing else reads it.
    next_line_driver_enable = oe_s & ~in_reset;
    for (int c = 0; c < glob_ctl_pkg::CHANNELS; c++)
    begin
      // With the enable low the hardware select is never looked at.
      next_channel_rate_mode[c] = hwe_s ? hws_s : channel_rate_mode_bit[c];
    end
    for (int g = 0; g < glob_ctl_pkg::GPIO_PINS; g++)
    begin
      next_gpio_oe[g] = gpio_reg[glob_ctl_pkg::GPIO_DIR_LSB + g] & ~in_reset;
      next_gpio_out[g] = gpio_reg[glob_ctl_pkg::GPIO_LEVEL_LSB + g];
      next_gpio_level_read[g] = gpio_reg[glob_ctl_pkg::GPIO_DIR_LSB + g]
        ? gpio_reg[glob_ctl_pkg::GPIO_LEVEL_LSB + g] : gpio_sync[g];
    end
    any_irq = |(irq_pending & ~irq_mask) & ~in_reset;
    next_host_alert_out = alert_level(any_irq, alert_style);
    // Open drain drives only when active, and only the low level is driven.
    next_host_alert_oe = alert_style[0] | (any_irq & ~alert_style[1]);
    if (!kind_s)
    begin
      next_host_port_kind = 2'(glob_ctl_pkg::PORT_SERIAL);
    end
    else if (!style_s)
    begin
      next_host_port_kind = 2'(glob_ctl_pkg::PORT_PAR_STROBE_RW);
    end
    else
    begin
      next_host_port_kind = 2'(glob_ctl_pkg::PORT_PAR_RD_WR);
    end
    next_host_port_multiplexed = kind_s & mux_s;
    // The port follows the select level; one fall per access is left to the host.
    next_host_port_active = ~cs_n_s & ~in_reset;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      line_driver_enable <= 1'b0;
      channel_rate_mode <= '0;
      gpio_out <= 2'h0;
      gpio_oe <= 2'h0;
      gpio_level_read <= 2'h0;
      host_alert_out <= 1'b1;
      host_alert_oe <= 1'b0;
      host_port_kind <= 2'h0;
      host_port_multiplexed <= 1'b0;
      host_port_active <= 1'b0;
    end
    else
    begin
      line_driver_enable <= next_line_driver_enable;
      channel_rate_mode <= next_channel_rate_mode;
      gpio_out <= next_gpio_out;
      gpio_oe <= next_gpio_oe;
      gpio_level_read <= next_gpio_level_read;
      host_alert_out <= next_host_alert_out;
      host_alert_oe <= next_host_alert_oe;
      host_port_kind <= next_host_port_kind;
      host_port_multiplexed <= next_host_port_multiplexed;
      host_port_active <= next_host_port_active;
    end
  end
endmodule
`default_nettype wire

// ==== hw/glob_ctl_pkg.sv ====
// Purpose: Shared constants for the global control and host port select block.
// Assumes: 20 MHz reference clock; field positions of the configuration bytes.
// Notes: Configuration registers arrive as plain ports from the register file.
`default_nettype none
package glob_ctl_pkg;
  localparam int CHANNELS = 22;
  // Channel configuration: rate mode bit.
  localparam int CH_RATE_BIT = 0;
  // General-purpose register fields.
  localparam int GPIO_DIR_LSB = 0;
  localparam int GPIO_LEVEL_LSB = 2;
  localparam int GPIO_PINS = 2;
  // Global configuration: alert pin style field.
  localparam int ALERT_STYLE_LSB = 2;
  localparam logic [1:0] ALERT_STYLE_RESET = 2'h0;
  // Rate modes.
  localparam logic RATE_E1 = 1'b0;
  localparam logic RATE_T1 = 1'b1;
  // Hardware reset sequence length, in ns and ref_clk cycles.
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_SEQ_NS = 2000;
  localparam int RESET_SEQ_CYCLES = RESET_SEQ_NS / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 6;
  // Cycles from a pin change to the filtered level, three stages plus agreement.
  localparam int PIN_SYNC_CYCLES = 4;
  // Host port kinds.
  typedef enum logic [1:0] {
    PORT_SERIAL,
    PORT_PAR_STROBE_RW,
    PORT_PAR_RD_WR
  } host_port_e;
endpackage
`default_nettype wire

// ==== hw/pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for slow pins.
// Assumes: Input is asynchronous to ref_clk.
// Notes: Output changes only when stages two and three agree.
`default_nettype none
module pin_sync #(
  parameter int         WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// ==== test/glob_ctl_monitor.sv ====
// Purpose: Port checks for the global control block.
// Assumes: Pins settle within eight steady cycles.
// Notes: Bound to every global_control instance.
`default_nettype none
module glob_ctl_monitor (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Watched ports
  input wire logic        reset_n_pin,
  input wire logic        driver_enable_pin,
  input wire logic        hw_rate_mode_enable,
  input wire logic        hw_rate_mode_select,
  input wire logic [21:0] channel_rate_mode_bit,
  input wire logic [3:0]  global_config_reg,
  input wire logic [21:0] irq_pending,
  input wire logic [21:0] irq_mask,
  input wire logic        chip_select_n,
  input wire logic        line_driver_enable,
  input wire logic [21:0] channel_rate_mode,
  input wire logic        host_alert_oe,
  input wire logic        device_reset,
  input wire logic        host_port_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Eight steady cycles cover the pin filter with a margin of one or two cycles.
  property p_off; (!driver_enable_pin)[*8] |-> !line_driver_enable; endproperty
  a_off: assert property (p_off) else $error("driver not off");
  property p_on; (driver_enable_pin && !device_reset)[*8] |-> line_driver_enable; endproperty
  a_on: assert property (p_on) else $error("driver not on");
  property p_pc; (!hw_rate_mode_enable)[*8] |->
    channel_rate_mode == $past(channel_rate_mode_bit); endproperty
  a_pc: assert property (p_pc) else $error("channel mode wrong");
  property p_hw; (hw_rate_mode_enable && $stable(hw_rate_mode_select))[*8] |->
    channel_rate_mode == {22{hw_rate_mode_select}}; endproperty
  a_hw: assert property (p_hw) else $error("global mode wrong");
  property p_al; (!device_reset && $stable(global_config_reg))[*2] |-> host_alert_oe ==
    (global_config_reg[2] | (|$past(irq_pending & ~irq_mask) & !global_config_reg[3]));
  endproperty
  a_al: assert property (p_al) else $error("alert drive wrong");
  property p_cs; chip_select_n[*8] |-> !host_port_active; endproperty
  a_cs: assert property (p_cs) else $error("port active unselected");
  property p_act; (!chip_select_n && !device_reset)[*8] |-> host_port_active; endproperty
  a_act: assert property (p_act) else $error("port not active");
  property p_rst; (!reset_n_pin)[*8] |-> device_reset && !line_driver_enable; endproperty
  a_rst: assert property (p_rst) else $error("reset not held");
endmodule
bind global_control glob_ctl_monitor mon (
  .ref_clk               (ref_clk),
  .reset                 (reset),
  .reset_n_pin           (reset_n_pin),
  .driver_enable_pin     (driver_enable_pin),
  .hw_rate_mode_enable   (hw_rate_mode_enable),
  .hw_rate_mode_select   (hw_rate_mode_select),
  .channel_rate_mode_bit (channel_rate_mode_bit),
  .global_config_reg     (global_config_reg),
  .irq_pending           (irq_pending),
  .irq_mask              (irq_mask),
  .chip_select_n         (chip_select_n),
  .line_driver_enable    (line_driver_enable),
  .channel_rate_mode     (channel_rate_mode),
  .host_alert_oe         (host_alert_oe),
  .device_reset          (device_reset),
  .host_port_active      (host_port_active)
);
`default_nettype wire

// ==== test/host_model.sv ====
// Purpose: Host that opens one access per request.
// Assumes: Access length of eight cycles.
// Notes: Select returns high between accesses.
`default_nettype none
module host_model (
  // Clock and request
  input  wire logic ref_clk,
  input  wire logic go,
  // Host pin
  output var logic  chip_select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial chip_select_n = 1'b1;
  // A new falling edge per access, with one high cycle between back-to-back requests.
  always @(posedge ref_clk)
    if (go && chip_select_n)
    begin
      chip_select_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chip_select_n <= 1'b1;
    end
endmodule
`default_nettype wire

// ==== test/global_control_tb.sv ====
// Purpose: Scenario bench for the global control block.
// Assumes: Pin effects settle within eight cycles.
// Notes: Host accesses come from the host model.
`default_nettype none
module global_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reset_n_pin = 1'b1;
  logic driver_enable_pin = 1'b0;
  logic hw_rate_mode_enable = 1'b1;
  logic hw_rate_mode_select = 1'b1;
  logic port_kind_strap = 1'b0;
  logic parallel_bus_style_select = 1'b1;
  logic bus_multiplex_select = 1'b1;
  logic go = 1'b0;
  logic [1:0] gpio_in = 2'h0;
  logic [3:0] gpio_reg = 4'h0;
  logic [3:0] global_config_reg = 4'h0;
  logic [21:0] channel_rate_mode_bit = 22'h0;
  logic [21:0] irq_pending = 22'h0;
  logic [21:0] irq_mask = 22'h0;
  logic [1:0] gpio_out, gpio_oe, gpio_level_read, host_port_kind;
  logic [21:0] channel_rate_mode;
  logic host_alert_out, host_alert_oe, chip_select_n, line_driver_enable;
  logic device_reset, host_port_multiplexed, host_port_active;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  always #25 ref_clk = ~ref_clk;
  global_control DUT (
    .ref_clk                   (ref_clk),
    .reset                     (reset),
    .reset_n_pin               (reset_n_pin),
    .driver_enable_pin         (driver_enable_pin),
    .hw_rate_mode_enable       (hw_rate_mode_enable),
    .hw_rate_mode_select       (hw_rate_mode_select),
    .gpio_in                   (gpio_in),
    .gpio_out                  (gpio_out),
    .gpio_oe                   (gpio_oe),
    .host_alert_out            (host_alert_out),
    .host_alert_oe             (host_alert_oe),
    .chip_select_n             (chip_select_n),
    .port_kind_strap           (port_kind_strap),
    .parallel_bus_style_select (parallel_bus_style_select),
    .bus_multiplex_select      (bus_multiplex_select),
    .channel_rate_mode_bit     (channel_rate_mode_bit),
    .gpio_reg                  (gpio_reg),
    .global_config_reg         (global_config_reg),
    .irq_pending               (irq_pending),
    .irq_mask                  (irq_mask),
    .gpio_level_read           (gpio_level_read),
    .line_driver_enable        (line_driver_enable),
    .channel_rate_mode         (channel_rate_mode),
    .device_reset              (device_reset),
    .host_port_kind            (host_port_kind),
    .host_port_multiplexed     (host_port_multiplexed),
    .host_port_active          (host_port_active)
  );
  host_model host (
    .ref_clk       (ref_clk),
    .go            (go),
    .chip_select_n (chip_select_n)
  );
  task chk(input string s, input logic [21:0] e, input logic [21:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wait_up();
    n = 0;
    while (device_reset !== 1'b0 && n < 60)
    begin
      wt(1);
      n++;
    end
    chk("reset wait", 1'b1, n < 60);
    if (n == 60)
      complete_run();
  endtask
  task t_drv();
    @(posedge ref_clk);
    hw_rate_mode_enable <= 1'b0;
    hw_rate_mode_select <= 1'b0;
    channel_rate_mode_bit <= 22'h2a5c31;
    wt(8);
    chk("driver", 1'b0, line_driver_enable);
    chk("mode", 22'h2a5c31, channel_rate_mode);
    @(posedge ref_clk);
    driver_enable_pin <= 1'b1;
    wt(8);
    chk("driver", 1'b1, line_driver_enable);
    $display("driver test ends");
  endtask
  task t_rate();
    @(posedge ref_clk);
    hw_rate_mode_enable <= 1'b1;
    wt(8);
    chk("mode", 22'h0, channel_rate_mode);
    @(posedge ref_clk);
    hw_rate_mode_select <= 1'b1;
    wt(8);
    chk("mode", 22'h3fffff, channel_rate_mode);
    $display("rate test ends");
  endtask
  task t_gpio();
    @(posedge ref_clk);
    gpio_reg <= 4'h9;
    gpio_in <= 2'h3;
    wt(8);
    chk("gpio oe", 2'h1, gpio_oe);
    chk("gpio out", 2'h2, gpio_out);
    chk("gpio read", 2'h2, gpio_level_read);
    @(posedge ref_clk);
    gpio_reg <= 4'h7;
    gpio_in <= 2'h2;
    wt(8);
    chk("gpio read", 2'h1, gpio_level_read);
    $display("gpio test ends");
  endtask
  task t_alert();
    logic a;
    logic [1:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s = i[1:0];
      a = !i[2];
      @(posedge ref_clk);
      global_config_reg <= {s, 2'h0};
      irq_pending <= 22'h20;
      irq_mask <= i[2] ? 22'h20 : 22'h0;
      wt(3);
      chk("alert oe", s[0] | (a & !s[1]), host_alert_oe);
      if (s[0] | (a & !s[1]))
        chk("alert", s[1] ? a : !a, host_alert_out);
    end
    $display("alert test ends");
  endtask
  task t_kind();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk);
      port_kind_strap <= k[1];
      parallel_bus_style_select <= k[0];
      bus_multiplex_select <= k[0];
      wt(8);
      chk("kind", k[1] ? (k[0] ? 2'h2 : 2'h1) : 2'h0, host_port_kind);
      chk("mux", k[1] & k[0], host_port_multiplexed);
    end
    $display("kind test ends");
  endtask
  task t_cs();
    for (int j = 0; j < 2; j++)
    begin
      @(posedge ref_clk);
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      wt(7);
      chk("active", 1'b1, host_port_active);
      wt(8);
      chk("active", 1'b0, host_port_active);
    end
    $display("select test ends");
  endtask
  task t_rst();
    @(posedge ref_clk);
    reset_n_pin <= 1'b0;
    wt(8);
    chk("dev reset", 1'b1, device_reset);
    chk("driver", 1'b0, line_driver_enable);
    @(posedge ref_clk);
    reset_n_pin <= 1'b1;
    wt(1);
    wait_up();
    // The count starts one cycle after the pin rose; the whole sequence must fit in 2 us.
    chk("reset time", 1'b1, n >= glob_ctl_pkg::RESET_SEQ_CYCLES - 8 && n < glob_ctl_pkg::RESET_SEQ_CYCLES);
    $display("reset test ends");
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    wt(1);
    wait_up();
    t_drv();
    t_rate();
    t_gpio();
    t_alert();
    t_kind();
    t_cs();
    t_rst();
    complete_run();
  end
endmodule
`default_nettype wire
